// >>> sigma_delta_pkg.sv
// Shared constants and types for the sigma-delta converter channel back end.
// Assumes a single 25 MHz clock domain; all users import the whole package.
package sigma_delta_pkg;

  localparam int RAW_W    = 30;
  localparam int ACC_W    = 31;
  localparam int RESULT_W = 16;

  // Base-two logarithm of each oversampling ratio.
  localparam logic [3:0] LOG2_OSR_32   = 4'h5;
  localparam logic [3:0] LOG2_OSR_64   = 4'h6;
  localparam logic [3:0] LOG2_OSR_128  = 4'h7;
  localparam logic [3:0] LOG2_OSR_256  = 4'h8;
  localparam logic [3:0] LOG2_OSR_512  = 4'h9;
  localparam logic [3:0] LOG2_OSR_1024 = 4'hA;

  // Ratio select field encodings.
  localparam logic [1:0] RATIO_SEL_0 = 2'h0;
  localparam logic [1:0] RATIO_SEL_1 = 2'h1;
  localparam logic [1:0] RATIO_SEL_2 = 2'h2;

  // Conversion number at which result events are first raised, per delay select.
  localparam logic [1:0] DELAY_SEL_FOURTH = 2'h0;
  localparam logic [1:0] DELAY_SEL_THIRD  = 2'h1;
  localparam logic [1:0] DELAY_SEL_SECOND = 2'h2;
  localparam logic [2:0] SETTLE_FOURTH    = 3'h4;
  localparam logic [2:0] SETTLE_THIRD     = 3'h3;
  localparam logic [2:0] SETTLE_SECOND    = 3'h2;
  localparam logic [2:0] SETTLE_FIRST     = 3'h1;

  // Modulator clock divider: divide by 1, 2, 4 or 8.
  localparam logic [2:0] DIV_MAX_1 = 3'h0;
  localparam logic [2:0] DIV_MAX_2 = 3'h1;
  localparam logic [2:0] DIV_MAX_4 = 3'h3;
  localparam logic [2:0] DIV_MAX_8 = 3'h7;

  // Values after reset.
  localparam logic                RESET_LOW_BITS_ACCESS = 1'b0;
  localparam logic [RESULT_W-1:0] RESET_READ_DATA       = 16'h0000;
  localparam logic [2:0]          RESET_CONV_COUNT      = 3'h0;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_SYNC,
    CONV_RUN
  } conv_state_t;

  typedef struct packed {
    logic unipolar_select;
    logic twos_complement_select;
  } data_format_t;

  typedef struct packed {
    logic [1:0] oversampling_ratio_select;
    logic       extended_ratio_select;
  } ratio_cfg_t;

  typedef struct packed {
    logic strobe;
    logic byte_wide;
  } result_read_t;

endpackage : sigma_delta_pkg

// >>> sinc3_decimator.sv
// Third-order comb decimator for a one-bit modulator stream.
// Assumes sample_tick is a one-cycle strobe on clock and log2 ratio is 5 to 10.
`timescale 1ns/1ps
module sinc3_decimator
  import sigma_delta_pkg::*;
#(
  parameter int STAGES = 3
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             clear,
  input  wire logic             sample_tick,
  input  wire logic             sample_bit,
  input  wire logic [3:0]       ratio_log2,
  output logic                  out_valid,
  output logic [RAW_W-1:0]      out_value
);

  wire  [ACC_W-1:0] integ [STAGES+1];
  wire  [ACC_W-1:0] diff  [STAGES+1];
  logic [9:0]       phase;

  wire [9:0]       phase_last = 10'((32'h1 << ratio_log2) - 1);
  wire             decimate   = sample_tick && (phase == phase_last);
  wire [5:0]       raw_width  = 6'(3 * ratio_log2);
  wire [ACC_W-1:0] full_scale = ACC_W'(1) << raw_width;

  assign integ[0] = {{(ACC_W-1){1'b0}}, sample_bit};
  assign diff[0]  = integ[STAGES];

  genvar s;
  generate
    for (s = 0; s < STAGES; s++) begin : g_stage
      logic [ACC_W-1:0] acc;
      logic [ACC_W-1:0] delay;
      // Integrators run at the modulator rate, combs at the decimated rate.
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          acc   <= '0;
          delay <= '0;
        end else if (clear) begin
          acc   <= '0;
          delay <= '0;
        end else begin
          if (sample_tick) begin
            acc <= acc + integ[s];
          end
          if (decimate) begin
            delay <= diff[s];
          end
        end
      end
      assign integ[s+1] = acc;
      assign diff[s+1]  = diff[s] - delay;
    end
  endgenerate

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase     <= '0;
      out_valid <= 1'b0;
      out_value <= '0;
    end else if (clear) begin
      phase     <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= decimate;
      if (sample_tick) begin
        phase <= decimate ? 10'h000 : phase + 10'h001;
      end
      // Exact full scale needs one more bit than the output has, so it is clipped.
      if (decimate) begin
        out_value <= (diff[STAGES] >= full_scale) ?
                     RAW_W'(full_scale - ACC_W'(1)) : RAW_W'(diff[STAGES]);
      end
    end
  end

endmodule : sinc3_decimator

// >>> sigma_delta_channel.sv
// One converter channel back end: clock selection, decimation, result formatting,
// result read path, flags and start/stop control including channel grouping.
// Assumes software controls arrive as same-clock strobes and levels, and the
// modulator bit arrives from the analog side asynchronously.
`timescale 1ns/1ps
module sigma_delta_channel
  import sigma_delta_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic                        modulator_bit,
  input  wire logic [2:0]                  source_ticks,
  input  wire logic [1:0]                  modulator_clock_source,
  input  wire logic [1:0]                  modulator_clock_divider,
  input  wire sigma_delta_pkg::ratio_cfg_t   ratio_cfg,
  input  wire sigma_delta_pkg::data_format_t data_format,
  input  wire logic [1:0]                  interrupt_delay_select,
  input  wire logic                        single_conversion_select,
  input  wire logic                        group_with_next,
  input  wire logic                        prev_group_with_next,
  input  wire logic                        master_start,
  input  wire logic                        master_decimate,
  input  wire logic                        start_set,
  input  wire logic                        start_clear,
  input  wire sigma_delta_pkg::result_read_t result_read,
  input  wire logic                        low_bits_access_write,
  input  wire logic                        low_bits_access_value,
  input  wire logic                        low_bits_toggle,
  input  wire logic                        ready_clear,
  input  wire logic                        overrun_clear,
  output logic [RESULT_W-1:0]              read_data,
  output logic                             start_conversion_bit,
  output logic                             low_bits_access,
  output logic                             result_ready_flag,
  output logic                             result_overrun_flag,
  output logic                             is_group_master,
  output logic                             decimate_pulse
);

  import sigma_delta_pkg::*;

  conv_state_t      state;
  conv_state_t      next_state;
  logic             bit_meta;
  logic             bit_sync;
  logic [2:0]       div_count;
  logic             master_start_q;
  logic [2:0]       conv_count;
  logic [RAW_W-1:0] raw_q;
  logic [3:0]       raw_log2_q;
  logic             filter_valid;
  logic [RAW_W-1:0] filter_value;

  // Modulator tick: source select, then divide by 1, 2, 4 or 8.
  wire       source_tick = (modulator_clock_source == 2'h0) ? 1'b1 :
                           source_ticks[modulator_clock_source - 2'h1];
  wire [2:0] div_max     = (modulator_clock_divider == 2'h0) ? DIV_MAX_1 :
                           (modulator_clock_divider == 2'h1) ? DIV_MAX_2 :
                           (modulator_clock_divider == 2'h2) ? DIV_MAX_4 : DIV_MAX_8;
  wire       mod_tick    = source_tick && (div_count == div_max);

  // Ratio decode; unused extended encodings fall back to the largest ratio.
  wire [1:0] rsel       = ratio_cfg.oversampling_ratio_select;
  wire [3:0] ratio_log2 = !ratio_cfg.extended_ratio_select ?
                          ((rsel == RATIO_SEL_0) ? LOG2_OSR_256 :
                           (rsel == RATIO_SEL_1) ? LOG2_OSR_128 :
                           (rsel == RATIO_SEL_2) ? LOG2_OSR_64  : LOG2_OSR_32) :
                          ((rsel == RATIO_SEL_0) ? LOG2_OSR_512 : LOG2_OSR_1024);

  // Grouping roles.
  wire grouped_slave = group_with_next;
  wire master_rise   = master_start && !master_start_q;
  wire master_fall   = !master_start && master_start_q;
  assign is_group_master = !group_with_next && prev_group_with_next;

  // A channel that is not running keeps its filter cleared.
  wire running      = (state == CONV_RUN);
  wire filter_clear = !running;
  assign decimate_pulse = running && filter_valid;

  // Settling count before results are announced.
  wire [2:0] settle_need = (interrupt_delay_select == DELAY_SEL_FOURTH) ? SETTLE_FOURTH :
                           (interrupt_delay_select == DELAY_SEL_THIRD)  ? SETTLE_THIRD  :
                           (interrupt_delay_select == DELAY_SEL_SECOND) ? SETTLE_SECOND :
                                                                          SETTLE_FIRST;
  wire [2:0] conv_number = (conv_count == 3'h7) ? conv_count : conv_count + 3'h1;
  wire       settled     = conv_number >= settle_need;
  wire       new_result  = decimate_pulse;
  wire       announce    = new_result && settled;
  wire       single_done = announce && single_conversion_select;

  // Start bit control: set by software or master, cleared by software, master or
  // completion of a single conversion; a set in the same cycle wins.
  wire start_on  = start_set || (grouped_slave && master_rise);
  wire start_off = start_clear || (grouped_slave && master_fall) || single_done;
  wire next_start = start_on ? 1'b1 : (start_off ? 1'b0 : start_conversion_bit);

  always_comb begin
    next_state = state;
    case (state)
      CONV_IDLE: begin
        if (next_start) begin
          next_state = grouped_slave ? CONV_SYNC : CONV_RUN;
        end
      end
      CONV_SYNC: begin
        if (!next_start) begin
          next_state = CONV_IDLE;
        end else if (master_decimate) begin
          next_state = CONV_RUN;
        end
      end
      CONV_RUN: begin
        if (!next_start) begin
          next_state = CONV_IDLE;
        end
      end
      default: begin
        next_state = CONV_IDLE;
      end
    endcase
  end

  // Result formatting.
  wire [5:0]       raw_width   = 6'(3 * raw_log2_q);
  wire [RAW_W-1:0] sign_bit    = RAW_W'(1) << (raw_width - 6'h01);
  wire             twos_mode   = data_format.twos_complement_select &&
                                 !data_format.unipolar_select;
  wire [RAW_W-1:0] raw_fmt     = twos_mode ? (raw_q ^ sign_bit) : raw_q;
  wire [4:0]       align_shift = 5'(6'h1E - raw_width);
  wire [RAW_W-1:0] aligned     = raw_fmt << align_shift;
  wire [RAW_W-1:0] above_mid   = aligned[RAW_W-1] ?
                                 {1'b0, aligned[RAW_W-2:0]} : '0;
  wire [RESULT_W-1:0] bipolar_word  = aligned[RAW_W-1:RAW_W-16];
  wire [RESULT_W-1:0] unipolar_word = above_mid[RAW_W-2:RAW_W-17];
  wire [RESULT_W-1:0] high_word     = data_format.unipolar_select ?
                                      unipolar_word : bipolar_word;
  wire [RESULT_W-1:0] low_word      = raw_fmt[RESULT_W-1:0];
  wire [RESULT_W-1:0] byte_word     = {8'h00, raw_fmt[7:0]};
  wire [RESULT_W-1:0] read_select   = result_read.byte_wide ? byte_word :
                                      (low_bits_access ? low_word : high_word);

  // Low-bit access: toggled by reads only, never by writes of the toggle bit.
  wire next_access = result_read.strobe && low_bits_toggle ? !low_bits_access :
                     (low_bits_access_write ? low_bits_access_value : low_bits_access);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bit_meta <= 1'b0;
      bit_sync <= 1'b0;
    end else begin
      bit_meta <= modulator_bit;
      bit_sync <= bit_meta;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_count <= '0;
    end else if (source_tick) begin
      div_count <= (div_count >= div_max) ? 3'h0 : div_count + 3'h1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state                <= CONV_IDLE;
      start_conversion_bit <= 1'b0;
      master_start_q       <= 1'b0;
    end else begin
      state                <= next_state;
      start_conversion_bit <= next_start;
      master_start_q       <= master_start;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      conv_count <= RESET_CONV_COUNT;
    end else if (!running) begin
      conv_count <= RESET_CONV_COUNT;
    end else if (new_result) begin
      conv_count <= conv_number;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      raw_q      <= '0;
      raw_log2_q <= LOG2_OSR_256;
    end else if (new_result) begin
      raw_q      <= filter_value;
      raw_log2_q <= ratio_log2;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      result_ready_flag   <= 1'b0;
      result_overrun_flag <= 1'b0;
    end else begin
      if (announce) begin
        result_ready_flag <= 1'b1;
      end else if (result_read.strobe || ready_clear) begin
        result_ready_flag <= 1'b0;
      end
      if (announce && result_ready_flag && !result_read.strobe) begin
        result_overrun_flag <= 1'b1;
      end else if (overrun_clear) begin
        result_overrun_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      low_bits_access <= RESET_LOW_BITS_ACCESS;
      read_data       <= RESET_READ_DATA;
    end else begin
      low_bits_access <= next_access;
      if (result_read.strobe) begin
        read_data <= read_select;
      end
    end
  end

  sinc3_decimator #(
    .STAGES (3)
  ) u_filter (
    .clock       (clock),
    .reset       (reset),
    .clear       (filter_clear),
    .sample_tick (mod_tick),
    .sample_bit  (bit_sync),
    .ratio_log2  (ratio_log2),
    .out_valid   (filter_valid),
    .out_value   (filter_value)
  );

endmodule : sigma_delta_channel

// >>> sigma_delta_channel_sva.sv
// Concurrent checks on the ports of one converter channel back end.
// Assumes it is bound to the channel and samples on the rising clock edge.
`timescale 1ns/1ps
module sigma_delta_channel_sva
  import sigma_delta_pkg::*;
(
  input wire logic                          clock,
  input wire logic                          reset,
  input wire logic                          start_set,
  input wire logic                          start_clear,
  input wire logic                          group_with_next,
  input wire logic                          prev_group_with_next,
  input wire logic                          low_bits_access_write,
  input wire logic                          low_bits_toggle,
  input wire sigma_delta_pkg::ratio_cfg_t   ratio_cfg,
  input wire sigma_delta_pkg::data_format_t data_format,
  input wire sigma_delta_pkg::result_read_t result_read,
  input wire logic [RESULT_W-1:0]           read_data,
  input wire logic                          start_conversion_bit,
  input wire logic                          low_bits_access,
  input wire logic                          result_ready_flag,
  input wire logic                          result_overrun_flag,
  input wire logic                          is_group_master,
  input wire logic                          decimate_pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_START_SET: assert property (start_set |=> start_conversion_bit)
    else $error("start bit not set");
  AST_START_CLEAR: assert property (start_clear && !start_set |=> !start_conversion_bit)
    else $error("start bit not cleared");
  AST_STOPPED_QUIET: assert property (!start_conversion_bit |-> !decimate_pulse)
    else $error("result stored while stopped");
  AST_READY_CAUSE: assert property ($rose(result_ready_flag) |-> $past(decimate_pulse))
    else $error("ready flag without new result");
  AST_READY_READ: assert property (result_read.strobe && !decimate_pulse |=> !result_ready_flag)
    else $error("ready flag survives read");
  AST_OVERRUN: assert property ($rose(result_overrun_flag) |-> $past(result_ready_flag) && $past(decimate_pulse))
    else $error("overrun without unread result");
  AST_TOGGLE: assert property (result_read.strobe && low_bits_toggle && !low_bits_access_write
    |=> low_bits_access != $past(low_bits_access))
    else $error("access bit not toggled by read");
  AST_ACCESS_HOLD: assert property (!result_read.strobe && !low_bits_access_write
    |=> $stable(low_bits_access))
    else $error("access bit changed without access");
  AST_LOW_ZERO: assert property (result_read.strobe && !result_read.byte_wide && !low_bits_access
    && ratio_cfg == 3'h6 |=> read_data[0] == 1'b0)
    else $error("lowest bit not zero at ratio 32");
  AST_BYTE_READ: assert property (result_read.strobe && result_read.byte_wide
    && !data_format.twos_complement_select |=> read_data[15:8] == 8'h00)
    else $error("byte read upper bits set");
  AST_GROUP_MASTER: assert property (is_group_master == (!group_with_next && prev_group_with_next))
    else $error("group master decode wrong");
  AST_SPACING: assert property (decimate_pulse |=> (!decimate_pulse) [*8])
    else $error("results stored too close together");
  COV_AUTO_STOP: cover property ($fell(start_conversion_bit));
  COV_OVERRUN: cover property ($rose(result_overrun_flag));
  COV_TOGGLE_READ: cover property (result_read.strobe && low_bits_toggle);
endmodule : sigma_delta_channel_sva

// >>> modulator_model.sv
// Behavioural model of the analog modulator that feeds the channel its bit stream.
// Assumes the bench picks the pattern; bits change on the falling clock edge.
`timescale 1ns/1ps
module modulator_model (
  input  wire logic       clock,
  input  wire logic [1:0] mode,
  input  wire logic       rand_bit,
  output logic            modulator_bit
);
  // Patterns: 0 negative full scale, 1 positive full scale, 2 mid scale, 3 random.
  initial modulator_bit = 1'b0;
  always @(negedge clock) begin
    case (mode)
      2'h0: modulator_bit <= 1'b0;
      2'h1: modulator_bit <= 1'b1;
      2'h2: modulator_bit <= ~modulator_bit;
      default: modulator_bit <= rand_bit;
    endcase
  end
endmodule : modulator_model

// >>> sigma_delta_channel_tb.sv
// Self-checking bench for one converter channel with a modulator model.
// Assumes a lone channel clocked from the main clock; the bench drives the grouping inputs to stand in for a master.
`timescale 1ns/1ps
module sigma_delta_channel_tb;
  import sigma_delta_pkg::*;
  logic                clock = 1'b0;
  logic                reset = 1'b1;
  logic                modulator_bit;
  logic                rand_bit = 1'b0;
  logic [1:0]          mod_mode = 2'h0;
  logic [2:0]          source_ticks = 3'h0;
  logic [1:0]          modulator_clock_source = 2'h0, modulator_clock_divider = 2'h0;
  logic [1:0]          interrupt_delay_select = 2'h0;
  ratio_cfg_t          ratio_cfg = 3'h0;
  data_format_t        data_format = 2'h0;
  result_read_t        result_read = 2'h0;
  logic                single_conversion_select = 1'b0, group_with_next = 1'b0;
  logic                prev_group_with_next = 1'b0, master_start = 1'b0, master_decimate = 1'b0;
  logic                start_set = 1'b0, start_clear = 1'b0, low_bits_access_write = 1'b0;
  logic                low_bits_access_value = 1'b0, low_bits_toggle = 1'b0;
  logic                ready_clear = 1'b0, overrun_clear = 1'b0;
  logic [RESULT_W-1:0] read_data, d;
  logic                start_conversion_bit, low_bits_access, result_ready_flag;
  logic                result_overrun_flag, is_group_master, decimate_pulse;
  logic [31:0]         lfsr = 32'h3850;
  int                  n_mismatch = 0, cmp_count = 0, k;

  sigma_delta_channel i_sigma_delta_channel (
    .clock(clock), .reset(reset), .modulator_bit(modulator_bit), .source_ticks(source_ticks),
    .modulator_clock_source(modulator_clock_source),
    .modulator_clock_divider(modulator_clock_divider), .ratio_cfg(ratio_cfg),
    .data_format(data_format), .interrupt_delay_select(interrupt_delay_select),
    .single_conversion_select(single_conversion_select), .group_with_next(group_with_next),
    .prev_group_with_next(prev_group_with_next), .master_start(master_start),
    .master_decimate(master_decimate), .start_set(start_set), .start_clear(start_clear),
    .result_read(result_read), .low_bits_access_write(low_bits_access_write),
    .low_bits_access_value(low_bits_access_value), .low_bits_toggle(low_bits_toggle),
    .ready_clear(ready_clear), .overrun_clear(overrun_clear), .read_data(read_data),
    .start_conversion_bit(start_conversion_bit), .low_bits_access(low_bits_access),
    .result_ready_flag(result_ready_flag), .result_overrun_flag(result_overrun_flag),
    .is_group_master(is_group_master), .decimate_pulse(decimate_pulse));
  modulator_model i_modulator_model (.clock(clock), .mode(mod_mode), .rand_bit(rand_bit),
    .modulator_bit(modulator_bit));

  always #20 clock = ~clock;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  always @(negedge clock) begin
    lfsr <= lfsr_next(lfsr);
    rand_bit <= lfsr[0];
    prev_group_with_next <= lfsr[5];
    // Source two ticks every other clock; the other sources tick at random.
    source_ticks <= {lfsr[7], ~source_ticks[1], lfsr[6]};
  end

  function automatic logic [15:0] full_scale(input data_format_t f, input logic [1:0] m);
    if (f.unipolar_select) return (m == 2'h1) ? 16'hFFFF : 16'h0000;
    case (m)
      2'h1: return f.twos_complement_select ? 16'h7FFF : 16'hFFFF;
      2'h2: return f.twos_complement_select ? 16'h0000 : 16'h8000;
      default: return f.twos_complement_select ? 16'h8000 : 16'h0000;
    endcase
  endfunction : full_scale

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    @(negedge clock);
  endtask : pulse

  task automatic do_read(input logic bw);
    result_read = {1'b1, bw};
    @(negedge clock);
    result_read = 2'h0;
    d = read_data;
    @(negedge clock);
  endtask : do_read

  task automatic wait_ready(input int lim);
    k = 0;
    while (result_ready_flag !== 1'b1 && k < lim) begin
      @(negedge clock);
      k++;
    end
    if (k >= lim) check(1, 0);
  endtask : wait_ready

  task automatic next_dec(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (decimate_pulse !== 1'b1 && n < 2000);
  endtask : next_dec

  // Start a continuous run, wait for the first announced result, read it and stop.
  task automatic measure(input data_format_t f, input ratio_cfg_t r, input logic [1:0] m,
                         input logic bw);
    data_format = f;
    ratio_cfg = r;
    mod_mode = m;
    pulse(start_set);
    wait_ready(8000);
    do_read(bw);
    check(result_ready_flag, 1'b0);
    pulse(start_clear);
    check(start_conversion_bit, 1'b0);
  endtask : measure

  initial begin
    repeat (3) @(negedge clock);
    reset = 1'b0;
    check(read_data, 16'h0000);
    check({start_conversion_bit, low_bits_access, result_ready_flag, result_overrun_flag}, 0);
    check(is_group_master, prev_group_with_next);
    for (int f = 0; f < 3; f++) begin
      for (int m = 0; m < 3; m++) begin
        measure(data_format_t'(f[1:0]), 3'h0, m[1:0], 1'b0);
        check(d, full_scale(data_format_t'(f[1:0]), m[1:0]));
      end
    end
    $display("test formats done");
    for (int r = 0; r < 8; r++) begin
      measure(2'h2, r[2:0], 2'h1, 1'b0);
      check(d, (r == 6) ? 16'hFFFC : 16'hFFFF);
    end
    $display("test ratios done");
    measure(2'h0, 3'h6, 2'h3, 1'b0);
    check(d[0], 1'b0);
    measure(2'h2, 3'h6, 2'h3, 1'b0);
    check(d[1:0], 2'h0);
    measure(2'h0, 3'h6, 2'h3, 1'b1);
    check(d[15:8], 8'h00);
    measure(2'h0, 3'h0, 2'h2, 1'b1);
    check(d, 16'h0000);
    $display("test low bits done");
    ratio_cfg = 3'h6;
    mod_mode = 2'h2;
    pulse(start_set);
    wait_ready(500);
    low_bits_access_value = 1'b1;
    pulse(low_bits_access_write);
    do_read(1'b0);
    check(d, 16'h4000);
    low_bits_access_value = 1'b0;
    pulse(low_bits_access_write);
    low_bits_toggle = 1'b1;
    @(negedge clock);
    check(low_bits_access, 1'b0);
    do_read(1'b0);
    check({d, low_bits_access}, {16'h8000, 1'b1});
    do_read(1'b0);
    check({d, low_bits_access}, {16'h4000, 1'b0});
    low_bits_toggle = 1'b0;
    $display("test toggle done");
    wait_ready(100);
    repeat (40) @(negedge clock);
    check(result_overrun_flag, 1'b1);
    pulse(ready_clear);
    check(result_ready_flag, 1'b0);
    pulse(overrun_clear);
    check(result_overrun_flag, 1'b0);
    pulse(start_clear);
    k = 0;
    repeat (100) begin
      @(negedge clock);
      k += int'(decimate_pulse);
    end
    check(k, 0);
    $display("test flags and stop done");
    single_conversion_select = 1'b1;
    for (int s = 0; s < 4; s++) begin
      interrupt_delay_select = s[1:0];
      pulse(start_set);
      k = 0;
      repeat (250) begin
        @(negedge clock);
        k += int'(decimate_pulse);
      end
      check({start_conversion_bit, result_ready_flag}, 2'h1);
      check(k, 4 - s);
      do_read(1'b0);
    end
    single_conversion_select = 1'b0;
    interrupt_delay_select = 2'h0;
    $display("test single done");
    for (int v = 0; v < 4; v++) begin
      modulator_clock_divider = v[1:0];
      pulse(start_set);
      next_dec(k);
      next_dec(k);
      check(k, 32 << v);
      pulse(start_clear);
    end
    modulator_clock_divider = 2'h0;
    modulator_clock_source = 2'h2;
    pulse(start_set);
    next_dec(k);
    next_dec(k);
    check(k, 64);
    pulse(start_clear);
    modulator_clock_source = 2'h0;
    $display("test divider done");
    group_with_next = 1'b1;
    master_start = 1'b1;
    @(negedge clock);
    check({start_conversion_bit, is_group_master}, 2'h2);
    k = 0;
    repeat (100) begin
      @(negedge clock);
      k += int'(decimate_pulse);
    end
    check(k, 0);
    pulse(master_decimate);
    next_dec(k);
    next_dec(k);
    check(k, 32);
    master_start = 1'b0;
    @(negedge clock);
    check(start_conversion_bit, 1'b0);
    group_with_next = 1'b0;
    $display("test group done");
    finish_test();
  end

  initial begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
endmodule : sigma_delta_channel_tb

bind sigma_delta_channel sigma_delta_channel_sva i_sigma_delta_channel_sva (
  .clock(clock), .reset(reset), .start_set(start_set), .start_clear(start_clear),
  .group_with_next(group_with_next), .prev_group_with_next(prev_group_with_next),
  .low_bits_access_write(low_bits_access_write), .low_bits_toggle(low_bits_toggle),
  .ratio_cfg(ratio_cfg), .data_format(data_format), .result_read(result_read),
  .read_data(read_data), .start_conversion_bit(start_conversion_bit),
  .low_bits_access(low_bits_access), .result_ready_flag(result_ready_flag),
  .result_overrun_flag(result_overrun_flag), .is_group_master(is_group_master),
  .decimate_pulse(decimate_pulse));
